// *** include/tm8_pkg.sv ***
// constants, register map and state type of the 8-bit dual compare timer
package tm8_pkg;
  localparam logic [4:0] TM8_OFS_CTRL_A  = 5'h00;
  localparam logic [4:0] TM8_OFS_CTRL_B  = 5'h04;
  localparam logic [4:0] TM8_OFS_COUNT   = 5'h08;
  localparam logic [4:0] TM8_OFS_CMP_A   = 5'h0C;
  localparam logic [4:0] TM8_OFS_CMP_B   = 5'h10;
  localparam logic [4:0] TM8_OFS_FLAGS   = 5'h14;
  localparam logic [4:0] TM8_OFS_PIN_CFG = 5'h18;
  localparam logic [7:0] TM8_CA_MASK     = 8'hF3;
  localparam logic [7:0] TM8_CB_MASK     = 8'h0F;
  localparam int         TM8_CB_FORCE_A  = 7;
  localparam int         TM8_CB_FORCE_B  = 6;
  localparam int         TM8_CB_MODE_HI  = 3;
  localparam int         TM8_FLG_OVF     = 0;
  localparam int         TM8_FLG_MA      = 1;
  localparam int         TM8_FLG_MB      = 2;
  localparam int         TM8_CFG_DIR_A   = 0;
  localparam int         TM8_CFG_DIR_B   = 1;
  localparam int         TM8_CFG_PORT_A  = 2;
  localparam int         TM8_CFG_PORT_B  = 3;
  localparam logic [7:0] TM8_MAX         = 8'hFF;
  localparam logic [7:0] TM8_FLOOR       = 8'h00;
  localparam logic [2:0] TM8_MODE_NORMAL = 3'h0;
  localparam logic [2:0] TM8_MODE_CTC    = 3'h2;
  localparam logic [2:0] TM8_MODE_FAST_A = 3'h7;
  localparam logic [2:0] TM8_CS_STOP     = 3'h0;
  localparam logic [2:0] TM8_CS_DIV1     = 3'h1;
  localparam logic [2:0] TM8_CS_DIV8     = 3'h2;
  localparam logic [2:0] TM8_CS_DIV64    = 3'h3;
  localparam logic [2:0] TM8_CS_DIV256   = 3'h4;
  localparam logic [2:0] TM8_CS_DIV1024  = 3'h5;
  localparam logic [2:0] TM8_CS_EXT_FALL = 3'h6;
  localparam logic [9:0] TM8_PRE_M8      = 10'h007;
  localparam logic [9:0] TM8_PRE_M64     = 10'h03F;
  localparam logic [9:0] TM8_PRE_M256    = 10'h0FF;
  localparam logic [9:0] TM8_PRE_M1024   = 10'h3FF;

  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  cnt;
    logic [7:0]  cmp_a;
    logic [7:0]  cmp_b;
    logic [7:0]  act_a;
    logic [7:0]  act_b;
    logic        dir_dn;
    logic        blk;
    logic        wave_a;
    logic        wave_b;
    logic [2:0]  flags;
    logic [3:0]  pin_cfg;
    logic [9:0]  pre;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_s3;
    logic        ack;
    logic [31:0] rdata;
  } tm8_state_t;
endpackage

// *** verilog/tm8_timer.sv ***
// 8-bit timer/counter with two compare channels behind an Avalon-MM slave
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module tm8_timer
  import tm8_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        ext_count_pin_in,
  output logic             wave_pin_a_out,
  output logic             wave_pin_a_oe_out,
  output logic             wave_pin_b_out,
  output logic             wave_pin_b_oe_out
);

  tm8_state_t st_ff;
  tm8_state_t nxt_st;

  logic       req;
  logic       acc_wr;
  logic       wr_lane;
  logic       cnt_wr;
  logic [2:0] mode;
  logic [2:0] csel;
  logic       pwm;
  logic       phase;
  logic       top_is_a;
  logic [7:0] top;
  logic       at_top;
  logic       ma;
  logic       mb;
  logic       tick;
  logic       force_a;
  logic       force_b;
  logic       ovf_hit;

  // next waveform level of one channel on a timer tick or a forced strobe
  function automatic logic wave_calc(input logic cur, input logic [1:0] act,
                                     input logic hit, input logic top_hit,
                                     input logic up, input logic cmp_top,
                                     input logic pwm_m, input logic phase_m,
                                     input logic tog_ok);
    logic r;
    r = cur;
    if (!pwm_m) begin
      if (hit) begin
        case (act)
          2'h1:    r = ~cur;
          2'h2:    r = 1'b0;
          2'h3:    r = 1'b1;
          default: r = cur;
        endcase
      end
    end else if (act == 2'h1) begin
      if (hit && tog_ok) begin
        r = ~cur;
      end
    end else if (act[1]) begin
      if (cmp_top) begin
        if (top_hit) begin
          r = ~act[0];
        end
      end else if (phase_m) begin
        if (hit) begin
          r = up ? act[0] : ~act[0];
        end
      end else if (hit) begin
        r = act[0];
      end else if (top_hit) begin
        r = ~act[0];
      end
    end
    return r;
  endfunction

  // register read decode
  function automatic logic [31:0] rd_decode(input logic [4:0] a, input tm8_state_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == TM8_OFS_CTRL_A) begin
      d[7:0] = s.ctrl_a;
    end else if (a == TM8_OFS_CTRL_B) begin
      d[7:0] = s.ctrl_b;
    end else if (a == TM8_OFS_COUNT) begin
      d[7:0] = s.cnt;
    end else if (a == TM8_OFS_CMP_A) begin
      d[7:0] = s.cmp_a;
    end else if (a == TM8_OFS_CMP_B) begin
      d[7:0] = s.cmp_b;
    end else if (a == TM8_OFS_FLAGS) begin
      d[2:0] = s.flags;
    end else if (a == TM8_OFS_PIN_CFG) begin
      d[3:0] = s.pin_cfg;
    end
    return d;
  endfunction

  assign req      = avs_read_in | avs_write_in;
  assign acc_wr   = avs_write_in & st_ff.ack;
  assign wr_lane  = acc_wr & avs_byteenable_in[0];
  assign cnt_wr   = wr_lane && (avs_address_in == TM8_OFS_COUNT);
  assign mode     = {st_ff.ctrl_b[TM8_CB_MODE_HI], st_ff.ctrl_a[1:0]};
  assign csel     = st_ff.ctrl_b[2:0];
  assign pwm      = mode[0];
  assign phase    = mode[0] & ~mode[1];
  assign top_is_a = (mode == TM8_MODE_CTC) | (mode[2] & mode[0]);
  assign top      = top_is_a ? st_ff.act_a : TM8_MAX;
  assign at_top   = st_ff.cnt == top;
  assign ma       = (st_ff.cnt == st_ff.act_a) & ~st_ff.blk;
  assign mb       = (st_ff.cnt == st_ff.act_b) & ~st_ff.blk;

  // timer clock source
  always_comb begin
    case (csel)
      TM8_CS_STOP:     tick = 1'b0;
      TM8_CS_DIV1:     tick = 1'b1;
      TM8_CS_DIV8:     tick = (st_ff.pre & TM8_PRE_M8) == TM8_PRE_M8;
      TM8_CS_DIV64:    tick = (st_ff.pre & TM8_PRE_M64) == TM8_PRE_M64;
      TM8_CS_DIV256:   tick = (st_ff.pre & TM8_PRE_M256) == TM8_PRE_M256;
      TM8_CS_DIV1024:  tick = st_ff.pre == TM8_PRE_M1024;
      TM8_CS_EXT_FALL: tick = st_ff.ext_s3 & ~st_ff.ext_s2;
      default:         tick = st_ff.ext_s2 & ~st_ff.ext_s3;
    endcase
  end

  // forcing looks at the mode that the same write selects
  assign force_a = wr_lane && (avs_address_in == TM8_OFS_CTRL_B) &&
                   avs_writedata_in[TM8_CB_FORCE_A] &&
                   !(avs_writedata_in[TM8_CB_MODE_HI] ? st_ff.ctrl_a[0] : pwm);
  assign force_b = wr_lane && (avs_address_in == TM8_OFS_CTRL_B) &&
                   avs_writedata_in[TM8_CB_FORCE_B] &&
                   !(avs_writedata_in[TM8_CB_MODE_HI] ? st_ff.ctrl_a[0] : pwm);

  always_comb begin
    if (phase) begin
      ovf_hit = st_ff.cnt == TM8_FLOOR;
    end else if (mode == TM8_MODE_FAST_A) begin
      ovf_hit = at_top;
    end else begin
      ovf_hit = st_ff.cnt == TM8_MAX;
    end
  end

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.pre    = st_ff.pre + 10'h001;
    nxt_st.ext_s1 = ext_count_pin_in;
    nxt_st.ext_s2 = st_ff.ext_s1;
    nxt_st.ext_s3 = st_ff.ext_s2;
    nxt_st.ack    = req & ~st_ff.ack;
    if (req && !st_ff.ack) begin
      nxt_st.rdata = rd_decode(avs_address_in, st_ff);
    end
    if (!pwm) begin
      nxt_st.act_a = st_ff.cmp_a;
      nxt_st.act_b = st_ff.cmp_b;
    end else if (tick && at_top) begin
      nxt_st.act_a = st_ff.cmp_a;
      nxt_st.act_b = st_ff.cmp_b;
    end
    if (!phase) begin
      nxt_st.dir_dn = 1'b0;
    end
    if (tick) begin
      nxt_st.blk = 1'b0;
      if (phase) begin
        if (!st_ff.dir_dn) begin
          if (at_top) begin
            nxt_st.dir_dn = 1'b1;
            nxt_st.cnt    = st_ff.cnt - 8'h01;
          end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
          end
        end else if (st_ff.cnt == TM8_FLOOR) begin
          nxt_st.dir_dn = 1'b0;
          nxt_st.cnt    = st_ff.cnt + 8'h01;
        end else begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end
      end else if (top_is_a && at_top) begin
        nxt_st.cnt = TM8_FLOOR;
      end else begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
      end
      nxt_st.wave_a = wave_calc(st_ff.wave_a, st_ff.ctrl_a[7:6], ma, at_top,
                                ~st_ff.dir_dn, st_ff.act_a == top, pwm, phase,
                                mode[2]);
      nxt_st.wave_b = wave_calc(st_ff.wave_b, st_ff.ctrl_a[5:4], mb, at_top,
                                ~st_ff.dir_dn, st_ff.act_b == top, pwm, phase,
                                1'b0);
    end
    if (force_a) begin
      nxt_st.wave_a = wave_calc(nxt_st.wave_a, st_ff.ctrl_a[7:6], 1'b1, 1'b0,
                                1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    end
    if (force_b) begin
      nxt_st.wave_b = wave_calc(nxt_st.wave_b, st_ff.ctrl_a[5:4], 1'b1, 1'b0,
                                1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    end
    // flag clear by writing one; a same-cycle set wins
    if (wr_lane && (avs_address_in == TM8_OFS_FLAGS)) begin
      nxt_st.flags = st_ff.flags & ~avs_writedata_in[2:0];
    end
    if (tick) begin
      nxt_st.flags[TM8_FLG_OVF] = nxt_st.flags[TM8_FLG_OVF] | ovf_hit;
      nxt_st.flags[TM8_FLG_MA]  = nxt_st.flags[TM8_FLG_MA] | ma;
      nxt_st.flags[TM8_FLG_MB]  = nxt_st.flags[TM8_FLG_MB] | mb;
    end
    if (wr_lane) begin
      if (avs_address_in == TM8_OFS_CTRL_A) begin
        nxt_st.ctrl_a = avs_writedata_in[7:0] & TM8_CA_MASK;
      end else if (avs_address_in == TM8_OFS_CTRL_B) begin
        nxt_st.ctrl_b = avs_writedata_in[7:0] & TM8_CB_MASK;
      end else if (avs_address_in == TM8_OFS_COUNT) begin
        nxt_st.cnt = avs_writedata_in[7:0];
        nxt_st.blk = 1'b1;
      end else if (avs_address_in == TM8_OFS_CMP_A) begin
        nxt_st.cmp_a = avs_writedata_in[7:0];
      end else if (avs_address_in == TM8_OFS_CMP_B) begin
        nxt_st.cmp_b = avs_writedata_in[7:0];
      end else if (avs_address_in == TM8_OFS_PIN_CFG) begin
        nxt_st.pin_cfg = avs_writedata_in[3:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata_out    = st_ff.rdata;
  assign avs_waitrequest_out = req & ~st_ff.ack;
  assign wave_pin_a_out      = (st_ff.ctrl_a[7:6] != 2'h0) ? st_ff.wave_a :
                               st_ff.pin_cfg[TM8_CFG_PORT_A];
  assign wave_pin_b_out      = (st_ff.ctrl_a[5:4] != 2'h0) ? st_ff.wave_b :
                               st_ff.pin_cfg[TM8_CFG_PORT_B];
  assign wave_pin_a_oe_out   = st_ff.pin_cfg[TM8_CFG_DIR_A];
  assign wave_pin_b_oe_out   = st_ff.pin_cfg[TM8_CFG_DIR_B];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  property p_rsvd;
    (st_ff.ctrl_a[3:2] == 2'h0) && (st_ff.ctrl_b[7:4] == 4'h0) &&
    (avs_readdata_out[31:8] == 24'h00_0000);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  property p_stop;
    (csel == TM8_CS_STOP && !cnt_wr) |=> $stable(st_ff.cnt);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");

  property p_div1;
    (csel == TM8_CS_DIV1 && mode == TM8_MODE_NORMAL && !cnt_wr)
      |=> st_ff.cnt == $past(st_ff.cnt) + 8'h01;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided count wrong");

  property p_div8;
    (csel == TM8_CS_DIV8 && tick) |=> (!tick || csel != TM8_CS_DIV8) [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 too fast");

  property p_ctc;
    (tick && mode == TM8_MODE_CTC && at_top && !cnt_wr) |=> st_ff.cnt == TM8_FLOOR;
  endproperty
  a_ctc: assert property (p_ctc) else $error("no return to zero");

  property p_ovf;
    (tick && mode == TM8_MODE_NORMAL && st_ff.cnt == TM8_MAX)
      |=> st_ff.flags[TM8_FLG_OVF];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missed");

  property p_pinb;
    (wave_pin_b_oe_out == st_ff.pin_cfg[TM8_CFG_DIR_B]) &&
    ((st_ff.ctrl_a[5:4] == 2'h0) || (wave_pin_b_out == st_ff.wave_b));
  endproperty
  a_pinb: assert property (p_pinb) else $error("pin b routing wrong");

  property p_force;
    (force_b && st_ff.ctrl_a[5:4] == 2'h3 && !tick)
      |=> st_ff.wave_b && !$rose(st_ff.flags[TM8_FLG_MB]);
  endproperty
  a_force: assert property (p_force) else $error("force b wrong");

  property p_imm;
    (wr_lane && avs_address_in == TM8_OFS_CMP_B && !pwm)
      |=> ##1 (pwm || st_ff.act_b == $past(st_ff.cmp_b));
  endproperty
  a_imm: assert property (p_imm) else $error("compare not immediate");

  property p_turn;
    (tick && phase && !st_ff.dir_dn && at_top && !cnt_wr)
      |=> st_ff.dir_dn && (st_ff.cnt == $past(st_ff.cnt) - 8'h01);
  endproperty
  a_turn: assert property (p_turn) else $error("phase turn wrong");

  property p_blk;
    cnt_wr |=> st_ff.blk && !ma && !mb;
  endproperty
  a_blk: assert property (p_blk) else $error("match not blocked");

  property p_ext_fall;
    (csel == TM8_CS_EXT_FALL && st_ff.ext_s3 && !st_ff.ext_s2 &&
     mode == TM8_MODE_NORMAL && !cnt_wr) |=> st_ff.cnt == $past(st_ff.cnt) + 8'h01;
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("pin edge not counted");

  property p_ext_idle;
    (csel == TM8_CS_EXT_FALL && !(st_ff.ext_s3 && !st_ff.ext_s2) && !cnt_wr)
      |=> $stable(st_ff.cnt);
  endproperty
  a_ext_idle: assert property (p_ext_idle) else $error("count without pin edge");

  property p_flag_ma;
    (tick && ma) |=> st_ff.flags[TM8_FLG_MA];
  endproperty
  a_flag_ma: assert property (p_flag_ma) else $error("match a flag missed");

  property p_flag_mb;
    (tick && mb) |=> st_ff.flags[TM8_FLG_MB];
  endproperty
  a_flag_mb: assert property (p_flag_mb) else $error("match b flag missed");

  property p_flag_clr;
    (wr_lane && avs_address_in == TM8_OFS_FLAGS && avs_writedata_in[TM8_FLG_OVF] && !tick)
      |=> !st_ff.flags[TM8_FLG_OVF];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_floor;
    (tick && phase && st_ff.dir_dn && st_ff.cnt == TM8_FLOOR && !cnt_wr)
      |=> !st_ff.dir_dn && (st_ff.cnt == TM8_FLOOR + 8'h01);
  endproperty
  a_floor: assert property (p_floor) else $error("phase floor turn wrong");

  property p_phase_ovf;
    (tick && phase && st_ff.cnt == TM8_FLOOR) |=> st_ff.flags[TM8_FLG_OVF];
  endproperty
  a_phase_ovf: assert property (p_phase_ovf) else $error("phase overflow missed");

  property p_fast_b_cmp;
    (tick && pwm && !phase && st_ff.ctrl_a[5:4] == 2'h2 && mb && st_ff.act_b != top)
      |=> !st_ff.wave_b;
  endproperty
  a_fast_b_cmp: assert property (p_fast_b_cmp) else $error("fast b not cleared");

  property p_fast_b_top;
    (tick && pwm && !phase && st_ff.ctrl_a[5:4] == 2'h2 && at_top) |=> st_ff.wave_b;
  endproperty
  a_fast_b_top: assert property (p_fast_b_top) else $error("fast b not set");

  property p_phase_b;
    (tick && phase && st_ff.ctrl_a[5:4] == 2'h2 && mb && !st_ff.dir_dn &&
     st_ff.act_b != top) |=> !st_ff.wave_b;
  endproperty
  a_phase_b: assert property (p_phase_b) else $error("phase b up match wrong");

  property p_force_keep;
    (force_a && !tick) |=> $stable(st_ff.cnt) && !$rose(st_ff.flags[TM8_FLG_MA]);
  endproperty
  a_force_keep: assert property (p_force_keep) else $error("force a side effect");

  property p_pwm_hold;
    (pwm && !(tick && at_top)) |=> $stable(st_ff.act_b);
  endproperty
  a_pwm_hold: assert property (p_pwm_hold) else $error("compare b not held");

  c_ctc:   cover property (tick && mode == TM8_MODE_CTC && at_top);
  c_turn:  cover property (tick && phase && !st_ff.dir_dn && at_top);
  c_ovf:   cover property ($rose(st_ff.flags[TM8_FLG_OVF]));
  c_force: cover property (force_b);
  c_ext:   cover property (tick && csel == TM8_CS_EXT_FALL);

endmodule // tm8_timer

// *** dv/tm8_pin_model.sv ***
// far-side pin model: drives the count pin, watches the channel B pin
`timescale 1ns/1ps
module tm8_pin_model (
  input  wire logic clk_in,
  input  wire logic wave_in,
  input  wire logic wave_oe_in,
  output logic      count_pin_out
);
  initial count_pin_out = 1'b0;

  // clean pulses, each level held well over one clock
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk_in);
      count_pin_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      count_pin_out <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
  endtask

  // high cycles of the driven pin over a window, after settling
  task automatic measure(input int win, output int hi);
    hi = 0;
    repeat (600) @(posedge clk_in);
    repeat (win) begin
      @(negedge clk_in);
      if (wave_oe_in === 1'b1 && wave_in === 1'b1) hi++;
    end
  endtask
endmodule // tm8_pin_model

// *** dv/tb_top.sv ***
// self-checking bench of the dual compare timer
`timescale 1ns/1ps
module tb_top
  import tm8_pkg::*;
;
  logic        clk_in;
  logic        srst_in;
  logic [4:0]  adr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdat;
  logic [3:0]  ben;
  logic [31:0] rdat;
  logic        wait_req;
  logic        cnt_pin;
  logic        pa;
  logic        pa_oe;
  logic        pb;
  logic        pb_oe;
  logic [31:0] q;
  logic [31:0] q0;
  logic [2:0]  m;
  logic [1:0]  act;
  int          hi;
  int          ex;
  int          num_errors;
  int          n_checks;

  tm8_timer u_dut (
    .clk_in              (clk_in),
    .srst_in             (srst_in),
    .avs_address_in      (adr),
    .avs_read_in         (rd_en),
    .avs_write_in        (wr_en),
    .avs_writedata_in    (wdat),
    .avs_byteenable_in   (ben),
    .avs_readdata_out    (rdat),
    .avs_waitrequest_out (wait_req),
    .ext_count_pin_in    (cnt_pin),
    .wave_pin_a_out      (pa),
    .wave_pin_a_oe_out   (pa_oe),
    .wave_pin_b_out      (pb),
    .wave_pin_b_oe_out   (pb_oe)
  );

  tm8_pin_model u_pin (
    .clk_in        (clk_in),
    .wave_in       (pb),
    .wave_oe_in    (pb_oe),
    .count_pin_out (cnt_pin)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one request held until waitrequest is seen low
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    int i;
    r = 32'h0000_0000;
    @(posedge clk_in);
    adr   <= a;
    wdat  <= {24'h0000_00, d};
    wr_en <= we;
    rd_en <= ~we;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_in);
      if (wait_req === 1'b0) begin
        r = rdat;
        break;
      end
    end
    if (i == 50) begin
      num_errors++;
      report_and_stop();
    end
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    bus(1'b0, a, 8'h00, d);
  endtask

  function automatic int div_of(input int c);
    return (c == 2) ? 8 : (c == 3) ? 64 : (c == 4) ? 256 : (c == 5) ? 1024 : 1;
  endfunction

  function automatic int delta_of(input int c);
    return (c == 0) ? 0 : (c == 1) ? 3 : 1;
  endfunction

  function automatic int high_of(input int k);
    return (k == 0) ? 130 : (k == 1) ? 382 : (k == 2) ? 256 : (k == 3) ? 764 : 512;
  endfunction

  initial begin
    num_errors = 0;
    n_checks   = 0;
    srst_in = 1'b1;
    adr = 5'h00;
    rd_en = 1'b0;
    wr_en = 1'b0;
    wdat = 32'h0000_0000;
    ben = 4'hf;
    void'($urandom(32'hd4ac_fccf));
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    chk("pins_reset", 0, {pa, pb, pa_oe, pb_oe});
    for (int a = 0; a < 8; a++) begin
      rd(5'(a * 4), q);
      chk("reset_value", 0, q);
    end
    wr(TM8_OFS_CTRL_A, 8'hff);
    rd(TM8_OFS_CTRL_A, q);
    chk("control_a", 32'h0000_00f3, q);
    wr(TM8_OFS_CTRL_B, 8'h38);
    rd(TM8_OFS_CTRL_B, q);
    chk("control_b", 32'h0000_0008, q);
    wr(TM8_OFS_CTRL_B, 8'h00);
    wr(TM8_OFS_CTRL_A, 8'h00);
    repeat (6) begin
      m = 3'($urandom_range(0, 2));
      q0 = {24'h0000_00, 8'($urandom)};
      wr(5'(8 + m * 4), q0[7:0]);
      rd(5'(8 + m * 4), q);
      chk("reg_readback", q0, q);
    end
    wr(TM8_OFS_CMP_A, 8'h5a);
    @(posedge clk_in);
    ben <= 4'h0;
    wr(TM8_OFS_CMP_A, 8'ha5);
    ben <= 4'hf;
    rd(TM8_OFS_CMP_A, q);
    chk("masked_write", 32'h0000_005a, q);
    wr(5'h1c, 8'hff);
    rd(5'h1c, q);
    chk("unmapped", 0, q);
    // forced strobes walk set, toggle, toggle, clear
    wr(TM8_OFS_PIN_CFG, 8'h03);
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 4; i++) begin
        act = (i == 0) ? 2'h3 : (i == 3) ? 2'h2 : 2'h1;
        wr(TM8_OFS_CTRL_A, (ch == 1) ? {2'h0, act, 4'h0} : {act, 6'h00});
        wr(TM8_OFS_CTRL_B, (ch == 1) ? 8'h40 : 8'h80);
        repeat (3) @(negedge clk_in);
        chk("forced_wave", 32'(i % 2 == 0), (ch == 1) ? pb : pa);
      end
    end
    rd(TM8_OFS_CTRL_B, q);
    chk("force_readback", 0, q);
    rd(TM8_OFS_FLAGS, q);
    chk("force_flags", 0, q);
    wr(TM8_OFS_CTRL_A, 8'h00);
    wr(TM8_OFS_PIN_CFG, 8'h0f);
    @(negedge clk_in);
    chk("pins_port", 32'h0000_000f, {pa, pb, pa_oe, pb_oe});
    wr(TM8_OFS_PIN_CFG, 8'h0c);
    @(negedge clk_in);
    chk("pins_no_drive", 32'h0000_000c, {pa, pb, pa_oe, pb_oe});
    wr(TM8_OFS_CTRL_A, 8'h30);
    @(negedge clk_in);
    chk("pins_wave_b", 32'h0000_0008, {pa, pb, pa_oe, pb_oe});
    wr(TM8_OFS_PIN_CFG, 8'h03);
    for (int c = 0; c < 8; c++) begin
      wr(TM8_OFS_CTRL_B, 8'h00);
      wr(TM8_OFS_COUNT, 8'h00);
      wr(TM8_OFS_CTRL_B, 8'(c));
      if (c < 6) begin
        rd(TM8_OFS_COUNT, q0);
        repeat ((c < 2) ? 0 : div_of(c) - 3) @(posedge clk_in);
        rd(TM8_OFS_COUNT, q);
        chk("count_delta", delta_of(c), {24'h0000_00, q[7:0] - q0[7:0]});
      end else begin
        u_pin.pulse(c - 1);
        repeat (8) @(posedge clk_in);
        rd(TM8_OFS_COUNT, q);
        chk("ext_count", c - 1, q);
      end
    end
    for (int k = 0; k < 3; k++) begin
      m = (k == 0) ? 3'h2 : (k == 1) ? 3'h5 : 3'h7;
      ex = (k == 0) ? 5 : 4;
      wr(TM8_OFS_CTRL_B, 8'h00);
      wr(TM8_OFS_CTRL_A, 8'h00);
      wr(TM8_OFS_CMP_A, 8'(ex));
      wr(TM8_OFS_CTRL_A, {6'h00, m[1:0]});
      wr(TM8_OFS_COUNT, 8'h00);
      wr(TM8_OFS_FLAGS, 8'h07);
      wr(TM8_OFS_CTRL_B, {4'h0, m[2], 3'h1});
      repeat (6) begin
        repeat ($urandom_range(0, 7)) @(posedge clk_in);
        rd(TM8_OFS_COUNT, q);
        chk("count_below_top", 1, q <= ex);
      end
      rd(TM8_OFS_FLAGS, q);
      chk("flags", {1'b1, k != 0}, q[1:0]);
      wr(TM8_OFS_CTRL_B, 8'h00);
      wr(TM8_OFS_FLAGS, 8'h07);
      rd(TM8_OFS_FLAGS, q);
      chk("flags_cleared", 0, q);
    end
    for (int k = 0; k < 5; k++) begin
      m = (k == 2 || k == 3) ? 3'h1 : 3'h3;
      act = (k % 2 == 1) ? 2'h3 : 2'h2;
      wr(TM8_OFS_CTRL_B, 8'h00);
      wr(TM8_OFS_CTRL_A, 8'h00);
      wr(TM8_OFS_CMP_B, (k == 4) ? 8'hff : 8'h40);
      wr(TM8_OFS_COUNT, 8'h00);
      wr(TM8_OFS_CTRL_A, {2'h0, act, 2'h0, m[1:0]});
      wr(TM8_OFS_CTRL_B, 8'h01);
      u_pin.measure((m == 3'h3) ? 512 : 1020, hi);
      chk("b_high_near", 1, hi >= high_of(k) - 6 && hi <= high_of(k) + 6);
    end
    report_and_stop();
  end
endmodule // tb_top
